// *** verilog/ptw_regs.vh ***
// register offsets, field positions and timing constants of the protocol timers
`ifndef PTW_REGS_VH
`define PTW_REGS_VH
// register offsets from the chip-select base (byte addresses)
`define PTW_OFS_TMR0        8'h12
`define PTW_OFS_TMR1        8'h14
// field layout of a timer register
`define PTW_CNT_MSB         7
`define PTW_CNT_LSB         0
`define PTW_BIT_EN          8
`define PTW_BIT_WDOG        9
`define PTW_BIT_STAT        15
// underflow step: counter leaves FF and lands on FE
`define PTW_CNT_FF          8'hff
`define PTW_CNT_FE          8'hfe
`define PTW_CNT_RST         8'h00
// prescaler and watchdog figures
`define PTW_PRESCALE        1024
`define PTW_WDOG_DIV        16
`define PTW_RST_PULSE       16
`endif

// *** verilog/ptw_timer_chan.v ***
// one protocol timer channel: prescaler, watchdog divider and down-counter
`timescale 1ns/1ps
`default_nettype none
`include "ptw_regs.vh"
module ptw_timer_chan #(
  parameter PRESCALE = `PTW_PRESCALE,
  parameter WDOG_DIV = `PTW_WDOG_DIV,
  parameter WDOG_OK  = 1
) (
  // clock and reset
  input  wire       core_clk_i,
  input  wire       resetn_i,
  // baud rate generator tick, one cycle wide
  input  wire       baud_tick_i,
  // host access, already decoded
  input  wire       wr_lo_i,
  input  wire       wr_hi_i,
  input  wire       rd_i,
  input  wire [15:0] wdata_i,
  // state
  output wire [15:0] rdata_o,
  output reg        irq_o,
  output reg        wdog_fire_o
);
  // *****************************************************************
  // state
  // *****************************************************************
  reg  [9:0] pre_q;
  reg  [3:0] wdiv_q;
  reg  [7:0] cnt_q;
  reg        en_q;
  reg        wdog_q;
  reg        stat_q;
  reg        seen_q;
  wire       pre_tick;
  wire       cnt_tick;
  wire       uflow;
  wire       clr_req;

  assign pre_tick = en_q && baud_tick_i &&
                    (pre_q == PRESCALE[9:0] - 10'h001);
  assign cnt_tick = pre_tick &&
                    (!wdog_q || wdiv_q == WDOG_DIV[3:0] - 4'h1);
  assign uflow    = cnt_tick && cnt_q == `PTW_CNT_FF;
  // status clears by writing a zero, accepted only after a read saw it set
  assign clr_req  = wr_hi_i && !wdata_i[`PTW_BIT_STAT] && seen_q;
  assign rdata_o  = {stat_q, 5'h00, wdog_q, en_q, cnt_q};

  // *****************************************************************
  // counting
  // *****************************************************************
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      pre_q       <= 10'h000;
      wdiv_q      <= 4'h0;
      cnt_q       <= `PTW_CNT_RST;
      en_q        <= 1'b0;
      wdog_q      <= 1'b0;
      stat_q      <= 1'b0;
      seen_q      <= 1'b0;
      irq_o       <= 1'b0;
      wdog_fire_o <= 1'b0;
    end else begin
      if (en_q && baud_tick_i)
        pre_q <= pre_tick ? 10'h000 : pre_q + 10'h001;
      if (pre_tick && wdog_q)
        wdiv_q <= wdiv_q + 4'h1;
      // host load wins over a tick in the same cycle
      if (wr_lo_i)
        cnt_q <= wdata_i[`PTW_CNT_MSB:`PTW_CNT_LSB];
      else if (cnt_tick)
        cnt_q <= cnt_q - 8'h01;
      if (wr_hi_i) begin
        en_q   <= wdata_i[`PTW_BIT_EN];
        wdog_q <= (WDOG_OK != 0) && wdata_i[`PTW_BIT_WDOG];
      end
      if (rd_i && stat_q)
        seen_q <= 1'b1;
      // set beats clear; a set flag blocks a second interrupt
      if (uflow) begin
        stat_q <= 1'b1;
      end else if (clr_req) begin
        stat_q <= 1'b0;
        seen_q <= 1'b0;
      end
      irq_o       <= uflow && !stat_q;
      wdog_fire_o <= uflow && wdog_q;
    end
  end
endmodule
`default_nettype wire

// *** verilog/ptw_timers.v ***
// two protocol timers with watchdog reset output and host register access
`timescale 1ns/1ps
`default_nettype none
`include "ptw_regs.vh"
module ptw_timers #(
  parameter RST_PULSE = `PTW_RST_PULSE
) (
  // clock and reset
  input  wire       core_clk_i,
  input  wire       resetn_i,
  // baud rate generator tick of the serial_control_port
  input  wire       baud_tick_i,
  // host register bus
  input  wire       cs_n_i,
  input  wire       wr_n_i,
  input  wire       ube_n_i,
  input  wire       lbe_n_i,
  input  wire [7:0] addr_i,
  input  wire [15:0] wdata_i,
  output reg  [15:0] rdata_o,
  // interrupts
  output reg        nmi_o,
  output reg  [1:0] timer_irq_o,
  // reset pin, open drain
  input  wire       sys_reset_n_i,
  output reg        sys_reset_n_o,
  output reg        sys_reset_n_oe_o
);
  // *****************************************************************
  // pin synchronisers
  // *****************************************************************
  // bus strobes come from the host domain; two stages before use
  reg  [3:0] sync1_q;
  reg  [3:0] sync2_q;
  // synchronised copies of the host address and write data
  reg  [7:0] addr_s1_q;
  reg  [7:0] addr_s2_q;
  reg  [15:0] wdata_s1_q;
  reg  [15:0] wdata_s2_q;
  reg        acc_q;
  reg        sys_rst_s1_q;
  reg        sys_rst_s2_q;
  wire       cs_s;
  wire       rd_s;
  wire       wr_s;
  wire       acc_start;
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sync1_q      <= 4'hf;
      sync2_q      <= 4'hf;
      acc_q        <= 1'b0;
      sys_rst_s1_q <= 1'b1;
      sys_rst_s2_q <= 1'b1;
    end else begin
      sync1_q      <= {cs_n_i, wr_n_i, ube_n_i, lbe_n_i};
      sync2_q      <= sync1_q;
      acc_q        <= cs_s;
      sys_rst_s1_q <= sys_reset_n_i;
      sys_rst_s2_q <= sys_rst_s1_q;
    end
  end
  // address and data take the same two stages as the strobes, so they
  // line up with the synchronised chip-select edge; the host holds
  // them steady while selected, so no bit is caught half-way
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      addr_s1_q  <= 8'h00;
      addr_s2_q  <= 8'h00;
      wdata_s1_q <= 16'h0000;
      wdata_s2_q <= 16'h0000;
    end else begin
      addr_s1_q  <= addr_i;
      addr_s2_q  <= addr_s1_q;
      wdata_s1_q <= wdata_i;
      wdata_s2_q <= wdata_s1_q;
    end
  end

  // one action per chip-select assertion
  assign cs_s      = !sync2_q[3];
  assign acc_start = cs_s && !acc_q;
  assign wr_s      = acc_start && !sync2_q[2];
  assign rd_s      = acc_start && sync2_q[2];

  // *****************************************************************
  // address decode
  // *****************************************************************
  wire [1:0] sel;
  wire [1:0] wr_lo;
  wire [1:0] wr_hi;
  wire [1:0] rd;
  wire [31:0] rdata_all;
  wire [1:0] irq;
  wire [1:0] fire;
  reg  [15:0] rdata_d;
  assign sel[0] = addr_s2_q == `PTW_OFS_TMR0;
  assign sel[1] = addr_s2_q == `PTW_OFS_TMR1;

  // unmapped offsets read zero; sel is one-hot or empty, so a read
  // never shows a mix of two registers
  always @* begin
    case (sel)
      2'h1:    rdata_d = rdata_all[15:0];
      2'h2:    rdata_d = rdata_all[31:16];
      default: rdata_d = 16'h0000;
    endcase
  end

  // *****************************************************************
  // timer channels
  // *****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
      assign wr_lo[gi] = wr_s && sel[gi] && !sync2_q[0];
      assign wr_hi[gi] = wr_s && sel[gi] && !sync2_q[1];
      assign rd[gi]    = rd_s && sel[gi];
      // each channel keeps its own prescaler chain and status flag;
      // only timer 0 is built with the watchdog stage
      ptw_timer_chan #(
        .PRESCALE (`PTW_PRESCALE),
        .WDOG_DIV (`PTW_WDOG_DIV),
        .WDOG_OK  (gi == 0 ? 1 : 0)
      ) u_chan (
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .baud_tick_i (baud_tick_i),
        .wr_lo_i     (wr_lo[gi]),
        .wr_hi_i     (wr_hi[gi]),
        .rd_i        (rd[gi]),
        .wdata_i     (wdata_s2_q),
        .rdata_o     (rdata_all[gi*16 +: 16]),
        .irq_o       (irq[gi]),
        .wdog_fire_o (fire[gi])
      );
    end
  endgenerate

  // *****************************************************************
  // read data, interrupts and watchdog reset pulse
  // *****************************************************************
  // after the drive ends the pin must read high again before a new
  // pulse may start, so a line still held low elsewhere cannot make
  // the watchdog retrigger on its own release
  localparam [2:0] ST_IDLE   = 3'h1;
  localparam [2:0] ST_DRIVE  = 3'h2;
  localparam [2:0] ST_SETTLE = 3'h4;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  // drive cycles still to go
  reg  [4:0] pulse_q;
  reg  [4:0] pulse_d;

  always @* begin
    state_d = state_q;
    pulse_d = pulse_q;
    case (state_q)
      ST_IDLE: begin
        if (fire[0]) begin
          state_d = ST_DRIVE;
          pulse_d = RST_PULSE[4:0];
        end
      end
      ST_DRIVE: begin
        if (pulse_q == 5'h01) begin
          state_d = ST_SETTLE;
          pulse_d = 5'h00;
        end else begin
          pulse_d = pulse_q - 5'h01;
        end
      end
      ST_SETTLE: begin
        if (sys_rst_s2_q)
          state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        pulse_d = 5'h00;
      end
    endcase
  end

  // *****************************************************************
  // registered outputs
  // *****************************************************************
  // nmi and the per-timer pulses leave together, one cycle after the
  // channel raised its interrupt
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_o          <= 16'h0000;
      nmi_o            <= 1'b0;
      timer_irq_o      <= 2'h0;
      state_q          <= ST_IDLE;
      pulse_q          <= 5'h00;
      sys_reset_n_o    <= 1'b1;
      sys_reset_n_oe_o <= 1'b0;
    end else begin
      // read data holds until the next read access
      if (rd_s)
        rdata_o <= rdata_d;
      nmi_o            <= |irq;
      timer_irq_o      <= irq;
      state_q          <= state_d;
      pulse_q          <= pulse_d;
      sys_reset_n_o    <= state_d != ST_DRIVE;
      sys_reset_n_oe_o <= state_d == ST_DRIVE;
    end
  end
endmodule
`default_nettype wire

// *** test/ptw_host_model.sv ***
// host side model of the open-drain system reset line
`timescale 1ns/1ps
`default_nettype none
module ptw_host_model (
  // pin drive from the device
  input  wire logic oe_i,
  input  wire logic drv_i,
  // resolved pin level
  output wire logic pin_o
);
  // pull-up holds the line high once the device lets go
  assign pin_o = oe_i ? drv_i : 1'b1;
endmodule
`default_nettype wire

// *** test/ptw_timers_assertions.sv ***
// port-level assertions of the protocol timers
`timescale 1ns/1ps
`default_nettype none
module ptw_timers_assertions (
  // watched ports
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        cs_n_i,
  input wire logic [15:0] rdata_o,
  input wire logic        nmi_o,
  input wire logic [1:0]  timer_irq_o,
  input wire logic        sys_reset_n_o,
  input wire logic        sys_reset_n_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_nmi_src; nmi_o |-> timer_irq_o != 2'b00; endproperty
  a_nmi_src: assert property (p_nmi_src)
    else $error("nmi without timer interrupt");
  property p_irq_nmi; |timer_irq_o |-> nmi_o; endproperty
  a_irq_nmi: assert property (p_irq_nmi)
    else $error("timer interrupt without nmi");
  property p_irq_once;
    (timer_irq_o & $past(timer_irq_o)) == 2'b00;
  endproperty
  a_irq_once: assert property (p_irq_once)
    else $error("timer interrupt held two cycles");
  property p_drive_low; sys_reset_n_oe_o |-> !sys_reset_n_o; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("reset pin driven high");
  property p_pulse;
    $rose(sys_reset_n_oe_o) |-> sys_reset_n_oe_o[*8] ##1
      sys_reset_n_oe_o[*8] ##1 !sys_reset_n_oe_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse not sixteen cycles");
  property p_idle_high; !sys_reset_n_oe_o |-> sys_reset_n_o; endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("reset drive low while released");
  property p_gap; $fell(sys_reset_n_oe_o) |-> !sys_reset_n_oe_o[*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("reset pin retaken at once");
  property p_rd_quiet; cs_n_i[*6] |-> $stable(rdata_o); endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data moved without access");
endmodule
bind ptw_timers ptw_timers_assertions i_chk (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .cs_n_i(cs_n_i), .rdata_o(rdata_o), .nmi_o(nmi_o),
  .timer_irq_o(timer_irq_o), .sys_reset_n_o(sys_reset_n_o),
  .sys_reset_n_oe_o(sys_reset_n_oe_o));
`default_nettype wire

// *** test/tb_ptw_timers.sv ***
// self-checking bench of the protocol timers
`timescale 1ns/1ps
`default_nettype none
module tb_ptw_timers;
  logic        clk = 0, rst_n = 0, baud = 0, cs_n = 1, wr_n = 1;
  logic [1:0]  be_n = 2'b11, irq;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, rd, r0;
  logic        nmi, oe, drv, pin;
  int          failures = 0, cmp_count = 0, n1 = 0, nn = 0, t;
  always #10 clk = ~clk;
  always @(posedge clk) n1 <= n1 + irq[1];
  always @(posedge clk) nn <= nn + nmi;
  ptw_timers #(.RST_PULSE(16)) i_dut (.core_clk_i(clk), .resetn_i(rst_n),
    .baud_tick_i(baud), .cs_n_i(cs_n), .wr_n_i(wr_n), .ube_n_i(be_n[1]),
    .lbe_n_i(be_n[0]), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .nmi_o(nmi), .timer_irq_o(irq), .sys_reset_n_i(pin),
    .sys_reset_n_o(drv), .sys_reset_n_oe_o(oe));
  ptw_host_model i_host (.oe_i(oe), .drv_i(drv), .pin_o(pin));
  // one chip-select cycle; held until well past the answer
  task automatic acc(input logic w, input logic [1:0] b,
                     input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); #1;
    {cs_n, wr_n, be_n, addr, wdata} = {1'b0, ~w, b, a, d};
    repeat (6) @(posedge clk);
    rd = rdata;
    #1 {cs_n, wr_n} = 2'b11;
    repeat (3) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    baud = 1;
    acc(1, 2'b00, 8'h12, 16'h0055);
    repeat (200) @(posedge clk);
    acc(0, 2'b00, 8'h12, 16'h0000); chk(rd, 16'h0055);
    acc(1, 2'b10, 8'h12, 16'hffaa);
    acc(0, 2'b00, 8'h12, 16'h0000); chk(rd, 16'h00aa);
    acc(1, 2'b00, 8'h14, 16'h0203);
    acc(0, 2'b00, 8'h14, 16'h0000); chk(rd, 16'h0003);
    acc(0, 2'b00, 8'h10, 16'h0000); chk(rd, 16'h0000);
    $display("test registers done");
    acc(1, 2'b00, 8'h14, 16'h0101);
    t = 0;
    while (n1 == 0 && t < 4000) begin @(posedge clk); #1 t++; end
    chk(16'(n1), 16'h0001);
    acc(1, 2'b01, 8'h14, 16'h0100); // clear before any read is refused
    acc(0, 2'b00, 8'h14, 16'h0000); chk(rd, 16'h81fe);
    acc(0, 2'b00, 8'h12, 16'h0000); chk(rd, 16'h00aa);
    acc(1, 2'b10, 8'h14, 16'h0001);
    repeat (3100) @(posedge clk);
    chk(16'(n1), 16'h0001);
    acc(1, 2'b01, 8'h14, 16'h0100);
    acc(0, 2'b00, 8'h14, 16'h0000); chk({rd[15:8], 8'h00}, 16'h0100);
    r0 = rd;
    repeat (1014) @(posedge clk);
    acc(0, 2'b00, 8'h14, 16'h0000); chk(rd, r0 - 16'h0001);
    acc(1, 2'b10, 8'h14, 16'h0001);
    t = 0;
    while (n1 == 1 && t < 4000) begin @(posedge clk); #1 t++; end
    chk(16'(n1), 16'h0002);
    $display("test counting done");
    acc(1, 2'b00, 8'h12, 16'h0300); // timeout load avoids FE
    t = 0;
    while (!oe && t < 40000) begin @(posedge clk); #1 t++; end
    chk(16'(t >= 32000 && t <= 33000), 16'h0001);
    t = 0;
    while (oe && t < 40) begin
      chk({15'h0, pin}, 16'h0000);
      @(posedge clk); #1 t++;
    end
    chk(16'(t), 16'h0010);
    #1 chk({15'h0, pin}, 16'h0001);
    chk(16'(nn), 16'h0003);
    $display("test watchdog done");
    end_of_test;
  end
endmodule
`default_nettype wire
